// ==== core/uct_pkg.sv ====
// Constants shared by the second control register block of the serial port.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
package uct_pkg;

    // Register byte offsets.
    localparam logic [11:0] OFF_CTRL2  = 12'h000;
    localparam logic [11:0] OFF_CFG    = 12'h004;
    localparam logic [11:0] OFF_STATUS = 12'h008;

    // Second control register fields.
    localparam int BIT_TX_EMPTY_IRQ_EN   = 7;
    localparam int BIT_TX_DONE_IRQ_EN    = 6;
    localparam int BIT_RX_FULL_IRQ_EN    = 5;
    localparam int BIT_QUIET_LINE_IRQ_EN = 4;
    localparam int BIT_TX_ON             = 3;
    localparam int BIT_RX_ON             = 2;
    localparam int BIT_RX_STANDBY        = 1;
    localparam int BIT_BREAK_QUEUE_CTL   = 0;

    // Configuration register fields.
    localparam int BIT_LOOPBACK_SEL    = 0;
    localparam int BIT_RX_SOURCE_SEL   = 1;
    localparam int BIT_SINGLE_WIRE_DIR = 2;
    localparam int BIT_LONG_BREAK_SEL  = 3;
    localparam int BIT_WAKE_METHOD_SEL = 4;

    // Status register fields.
    localparam int BIT_ST_TX_PIN_OWN  = 0;
    localparam int BIT_ST_RX_PIN_OWN  = 1;
    localparam int BIT_ST_IRQ         = 2;
    localparam int BIT_ST_IDLE_PEND   = 3;
    localparam int BIT_ST_BREAK_PEND  = 4;
    localparam int BIT_ST_FLAGS_LSB   = 8;

    // Reset values.
    localparam logic [7:0] RST_CTRL2 = 8'h00;
    localparam logic [4:0] RST_CFG   = 5'h00;

    // AXI responses.
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : uct_pkg

// ==== core/uct_ctrl2.sv ====
// Control logic behind the second control register of an asynchronous
// serial port, with an AXI4-Lite slave for its registers.
// Assumes the transmitter, receiver and flag logic run on ref_clk and hand
// over flags, activity and taken pulses without synchronisation.
//
// Operation
// - Transmit-empty enable gates the transmit-buffer-empty flag onto the interrupt.
// - Transmit-done enable gates the transmission-complete flag onto the interrupt.
// - Receive-full enable gates the receive-buffer-full flag onto the interrupt.
// - Quiet-line enable gates the idle-line flag onto the interrupt.
// - Transmitter runs only while enabled and then owns the transmit pin.
// - Single-wire mode uses the direction bit to turn the transmit pin.
// - Transmitter enable written low then high while busy queues one idle.
// - Transmit pin stays driven until data, idle and breaks are sent.
// - Receiver enable low frees the receive pin; high runs the receiver.
// - Loopback keeps the receive pin free even with the receiver enabled.
// - Writing standby one parks the receiver waiting for its wakeup.
// - Wakeup is an idle line, or a set top data bit when selected.
// - Software sets standby; hardware clears it on the chosen wakeup.
// - Break control written one then zero queues one break character.
// - Breaks keep queuing while held; long select lengthens each break.
// - A second break may be queued before software clears the bit.
// - Loopback routes transmitter output to the receiver input internally.
// - The control register reads back the last written value, except standby, which a wakeup clears.

`timescale 1ns/1ps

module uct_ctrl2 (
    // Clock and reset.
    input  wire logic        ref_clk,
    input  wire logic        srst,

    // AXI4-Lite write address and data.
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,

    // AXI4-Lite write response.
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,

    // AXI4-Lite read.
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [11:0] s_axi_araddr,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,

    // Status flags from the flag logic.
    input  wire logic        tx_buf_empty_flag,
    input  wire logic        tx_done_flag,
    input  wire logic        rx_buf_full_flag,
    input  wire logic        idle_line_flag,

    // Transmitter handshake.
    input  wire logic        tx_busy,
    input  wire logic        idle_taken,
    input  wire logic        break_taken,

    // Receiver wakeup events.
    input  wire logic        idle_wake_evt,
    input  wire logic        addr_mark_evt,

    // Control outputs to the datapath and pins.
    output logic             serial_irq,
    output logic             tx_run,
    output logic             rx_run,
    output logic             rx_standby,
    output logic             idle_req,
    output logic             break_req,
    output logic             long_break_sel,
    output logic             loop_route,
    output logic             tx_pin_oe,
    output logic             rx_pin_own
);

    logic [7:0]  ctrl_r;
    logic [4:0]  cfg_r;
    logic        aw_got_r;
    logic        w_got_r;
    logic [11:0] waddr_r;
    logic [31:0] wdata_r;
    logic [3:0]  wstrb_r;
    logic        wr_fire;
    logic        wr_ctrl;
    logic        wr_cfg;
    logic [7:0]  ctrl_wval;
    logic        wake_hit;
    logic        idle_pend_r;
    logic        break_pend_r;
    logic        tx_pin_own;
    logic        single_wire;
    logic [3:0]  irq_src;
    logic [31:0] status_word;
    logic [31:0] rd_word;
    logic        rd_ok;

    // Write path: address and data may arrive in either order.
    assign wr_fire = aw_got_r && w_got_r && !s_axi_bvalid;
    assign wr_ctrl = wr_fire && (waddr_r == uct_pkg::OFF_CTRL2) && wstrb_r[0];
    assign wr_cfg  = wr_fire && (waddr_r == uct_pkg::OFF_CFG) && wstrb_r[0];
    assign ctrl_wval = wdata_r[7:0];

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s_axi_awready <= 1'b1;
            aw_got_r      <= 1'b0;
            waddr_r       <= 12'h000;
        end else if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            aw_got_r      <= 1'b1;
            waddr_r       <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_got_r      <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s_axi_wready <= 1'b1;
            w_got_r      <= 1'b0;
            wdata_r      <= 32'h0000_0000;
            wstrb_r      <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            w_got_r      <= 1'b1;
            wdata_r      <= s_axi_wdata;
            wstrb_r      <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_got_r      <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_wready <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= uct_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            if (waddr_r == uct_pkg::OFF_CTRL2 || waddr_r == uct_pkg::OFF_CFG
                || waddr_r == uct_pkg::OFF_STATUS) begin
                s_axi_bresp <= uct_pkg::RESP_OKAY;
            end else begin
                s_axi_bresp <= uct_pkg::RESP_SLVERR;
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Wakeup source follows the method select.
    assign wake_hit = cfg_r[uct_pkg::BIT_WAKE_METHOD_SEL] ? addr_mark_evt
                                                          : idle_wake_evt;

    // Control register; a software write of standby wins over the wakeup.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ctrl_r <= uct_pkg::RST_CTRL2;
        end else if (wr_ctrl) begin
            ctrl_r <= ctrl_wval;
        end else if (wake_hit) begin
            ctrl_r[uct_pkg::BIT_RX_STANDBY] <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cfg_r <= uct_pkg::RST_CFG;
        end else if (wr_cfg) begin
            cfg_r <= wdata_r[4:0];
        end
    end

    // Queued idle: a rising enable while the shifter is busy.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            idle_pend_r <= 1'b0;
        end else if (wr_ctrl && tx_busy && ctrl_wval[uct_pkg::BIT_TX_ON]
                     && !ctrl_r[uct_pkg::BIT_TX_ON]) begin
            idle_pend_r <= 1'b1;
        end else if (idle_taken) begin
            idle_pend_r <= 1'b0;
        end
    end

    // Queued break: one on the falling write, more while the bit stays set.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            break_pend_r <= 1'b0;
        end else if (wr_ctrl && ctrl_r[uct_pkg::BIT_BREAK_QUEUE_CTL]
                     && !ctrl_wval[uct_pkg::BIT_BREAK_QUEUE_CTL]) begin
            break_pend_r <= 1'b1;
        end else if (ctrl_r[uct_pkg::BIT_BREAK_QUEUE_CTL]) begin
            break_pend_r <= 1'b1;
        end else if (break_taken) begin
            break_pend_r <= 1'b0;
        end
    end

    // Pin ownership: the transmitter holds its pin until all queued work ends.
    assign tx_pin_own = ctrl_r[uct_pkg::BIT_TX_ON] || tx_busy
                        || idle_pend_r || break_pend_r;
    assign single_wire = cfg_r[uct_pkg::BIT_LOOPBACK_SEL]
                         && cfg_r[uct_pkg::BIT_RX_SOURCE_SEL];

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            tx_pin_oe <= 1'b0;
        end else begin
            tx_pin_oe <= tx_pin_own && (!single_wire
                         || cfg_r[uct_pkg::BIT_SINGLE_WIRE_DIR]);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rx_pin_own <= 1'b0;
            loop_route <= 1'b0;
        end else begin
            rx_pin_own <= ctrl_r[uct_pkg::BIT_RX_ON]
                          && !cfg_r[uct_pkg::BIT_LOOPBACK_SEL];
            loop_route <= cfg_r[uct_pkg::BIT_LOOPBACK_SEL];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            tx_run         <= 1'b0;
            rx_run         <= 1'b0;
            rx_standby     <= 1'b0;
            idle_req       <= 1'b0;
            break_req      <= 1'b0;
            long_break_sel <= 1'b0;
        end else begin
            tx_run         <= ctrl_r[uct_pkg::BIT_TX_ON];
            rx_run         <= ctrl_r[uct_pkg::BIT_RX_ON];
            rx_standby     <= ctrl_r[uct_pkg::BIT_RX_STANDBY];
            idle_req       <= idle_pend_r && !idle_taken;
            break_req      <= break_pend_r && !break_taken;
            long_break_sel <= cfg_r[uct_pkg::BIT_LONG_BREAK_SEL];
        end
    end

    // Interrupt request: any flag with its enable set.
    assign irq_src[3] = ctrl_r[uct_pkg::BIT_TX_EMPTY_IRQ_EN]
                        && tx_buf_empty_flag;
    assign irq_src[2] = ctrl_r[uct_pkg::BIT_TX_DONE_IRQ_EN]
                        && tx_done_flag;
    assign irq_src[1] = ctrl_r[uct_pkg::BIT_RX_FULL_IRQ_EN]
                        && rx_buf_full_flag;
    assign irq_src[0] = ctrl_r[uct_pkg::BIT_QUIET_LINE_IRQ_EN]
                        && idle_line_flag;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            serial_irq <= 1'b0;
        end else begin
            serial_irq <= |irq_src;
        end
    end

    // Read path.
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[uct_pkg::BIT_ST_TX_PIN_OWN] = tx_pin_own;
        status_word[uct_pkg::BIT_ST_RX_PIN_OWN] = rx_pin_own;
        status_word[uct_pkg::BIT_ST_IRQ]        = serial_irq;
        status_word[uct_pkg::BIT_ST_IDLE_PEND]  = idle_pend_r;
        status_word[uct_pkg::BIT_ST_BREAK_PEND] = break_pend_r;
        status_word[uct_pkg::BIT_ST_FLAGS_LSB +: 4] = {tx_buf_empty_flag,
            tx_done_flag, rx_buf_full_flag, idle_line_flag};
    end

    always_comb begin
        rd_word = 32'h0000_0000;
        rd_ok   = 1'b1;
        unique case (s_axi_araddr)
            uct_pkg::OFF_CTRL2:  rd_word = {24'h00_0000, ctrl_r};
            uct_pkg::OFF_CFG:    rd_word = {27'h000_0000, cfg_r};
            uct_pkg::OFF_STATUS: rd_word = status_word;
            default:             rd_ok   = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= uct_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= rd_ok ? uct_pkg::RESP_OKAY : uct_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
        end
    end

endmodule : uct_ctrl2

// ==== sim/uct_ctrl2_asserts.sv ====
// Checker on the ports of the second control register block.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module uct_ctrl2_asserts (
    // Clock, reset and bus.
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic s_axi_wready,
    // Datapath side.
    input wire logic tx_buf_empty_flag,
    input wire logic tx_done_flag,
    input wire logic rx_buf_full_flag,
    input wire logic idle_line_flag,
    input wire logic idle_taken,
    input wire logic break_taken,
    input wire logic idle_wake_evt,
    input wire logic addr_mark_evt,
    input wire logic serial_irq,
    input wire logic tx_run,
    input wire logic rx_run,
    input wire logic rx_standby,
    input wire logic idle_req,
    input wire logic break_req,
    input wire logic loop_route,
    input wire logic tx_pin_oe,
    input wire logic rx_pin_own
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    AST_IRQ_QUIET: assert property (!(tx_buf_empty_flag || tx_done_flag
        || rx_buf_full_flag || idle_line_flag) |=> !serial_irq)
        else $error("interrupt without any flag");
    AST_RX_PIN: assert property (
        rx_pin_own == (rx_run && !loop_route)) else $error("rx pin owner");
    AST_TX_PIN: assert property (tx_run && !loop_route |-> tx_pin_oe)
        else $error("tx pin not driven");
    AST_IDLE_HOLD: assert property (idle_req && !idle_taken |=> idle_req)
        else $error("idle request lost");
    AST_IDLE_DONE: assert property (idle_req && idle_taken |=> !idle_req)
        else $error("idle request stuck");
    AST_BRK_HOLD: assert property (break_req && !break_taken |=> break_req)
        else $error("break request lost");
    AST_STBY_HOLD: assert property (
        rx_standby && s_axi_wready && !idle_wake_evt && !addr_mark_evt
        && !$past(idle_wake_evt) && !$past(addr_mark_evt)
        |=> rx_standby) else $error("standby left without wakeup");
    AST_BRK_PIN: assert property (
        $past(break_req) && !loop_route |-> tx_pin_oe)
        else $error("pin released with break pending");
endmodule : uct_ctrl2_asserts

bind uct_ctrl2 uct_ctrl2_asserts chk_i (
    .ref_clk, .srst, .s_axi_wready, .tx_buf_empty_flag, .tx_done_flag,
    .rx_buf_full_flag, .idle_line_flag, .idle_taken, .break_taken,
    .idle_wake_evt, .addr_mark_evt, .serial_irq, .tx_run, .rx_run,
    .rx_standby, .idle_req, .break_req, .loop_route, .tx_pin_oe,
    .rx_pin_own);

// ==== sim/uct_line_model.sv ====
// Stand-in for the transmit shifter that serves queued idles and breaks.
// Assumes requests and taken pulses share ref_clk with the control block.
`timescale 1ns/1ps
module uct_line_model (
    // Clock, reset and stall.
    input  wire logic ref_clk,
    input  wire logic srst,
    input  wire logic busy_hold,
    // Requests from the control block.
    input  wire logic idle_req,
    input  wire logic break_req,
    input  wire logic long_break_sel,
    // Answers to the control block.
    output logic      tx_busy,
    output logic      idle_taken,
    output logic      break_taken
);
    logic [4:0] left_r;
    // One cycle stands for one bit time; queued work waits behind a stall.
    always_ff @(posedge ref_clk) begin
        idle_taken <= 1'b0;
        break_taken <= 1'b0;
        if (srst) begin
            left_r <= 5'h00;
        end else if (left_r != 5'h00) begin
            left_r <= left_r - 5'h01;
        end else if (!busy_hold && break_req) begin
            break_taken <= 1'b1;
            left_r <= long_break_sel ? 5'h0e : 5'h0b;
        end else if (!busy_hold && idle_req) begin
            idle_taken <= 1'b1;
            left_r <= 5'h0b;
        end
    end
    assign tx_busy = (left_r != 5'h00) || busy_hold;
endmodule : uct_line_model

// ==== sim/tb_top.sv ====
// Self-checking bench for the second control register block.
// Assumes the line model answers queued idles and breaks.
`timescale 1ns/1ps
module tb_top;
    localparam logic [11:0] CT = uct_pkg::OFF_CTRL2;
    localparam logic [11:0] CF = uct_pkg::OFF_CFG;
    logic        ref_clk = 1'b0, srst = 1'b1, busy_hold = 1'b0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0, idle_wake_evt = 1'b0;
    logic        addr_mark_evt = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_v;
    logic [3:0]  s_axi_wstrb = 4'hf, flg = 4'h0;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, tx_busy, idle_taken, break_taken, serial_irq;
    logic        tx_run, rx_run, rx_standby, idle_req, break_req;
    logic        long_break_sel, loop_route, tx_pin_oe, rx_pin_own;
    int          bad_count = 0, comparisons = 0, idle_n = 0, brk_n = 0;

    always #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        idle_n <= idle_n + int'(idle_taken);
        brk_n <= brk_n + int'(break_taken);
    end

    uct_ctrl2 uut (.ref_clk, .srst, .s_axi_awvalid, .s_axi_awready,
        .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
        .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
        .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
        .tx_buf_empty_flag(flg[3]), .tx_done_flag(flg[2]),
        .rx_buf_full_flag(flg[1]), .idle_line_flag(flg[0]), .tx_busy,
        .idle_taken, .break_taken, .idle_wake_evt, .addr_mark_evt,
        .serial_irq, .tx_run, .rx_run, .rx_standby, .idle_req, .break_req,
        .long_break_sel, .loop_route, .tx_pin_oe, .rx_pin_own);
    uct_line_model line_i (.ref_clk, .srst, .busy_hold, .idle_req,
        .break_req, .long_break_sel, .tx_busy, .idle_taken, .break_taken);

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wrap_up();
        $display("mismatches %0d comparisons %0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : wrap_up

    // One AXI4-Lite write (we=1) or read (we=0), waiting for the answer.
    task automatic acc(input logic we, input logic [11:0] a,
                       input logic [7:0] d);
        int n;
        logic [4:0] t;
        logic ok;
        n = 0;
        @(posedge ref_clk);
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, 24'h0, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{we}};
        {s_axi_arvalid, s_axi_rready} <= {2{!we}};
        do begin
            @(negedge ref_clk);
            t = {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready,
                 s_axi_rvalid};
            ok = we ? t[2] : t[0];
            rs = we ? s_axi_bresp : s_axi_rresp;
            rd_v = s_axi_rdata;
            n++;
            @(posedge ref_clk);
            if (t[4]) s_axi_awvalid <= 1'b0;
            if (t[3]) s_axi_wvalid <= 1'b0;
            if (t[2]) s_axi_bready <= 1'b0;
            if (t[1]) s_axi_arvalid <= 1'b0;
            if (t[0]) s_axi_rready <= 1'b0;
        end while (!ok && n < 40);
        if (!ok) begin
            bad_count++;
            wrap_up();
        end
    endtask : acc

    task automatic wt(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask : wt

    task automatic hit(input logic am);
        @(posedge ref_clk) {addr_mark_evt, idle_wake_evt} <= {am, !am};
        @(posedge ref_clk) {addr_mark_evt, idle_wake_evt} <= 2'b00;
        wt(1);
    endtask : hit

    initial begin
        repeat (5) @(posedge ref_clk);
        srst <= 1'b0;
        acc(1'b0, CT, 8'h00);
        chk(rd_v, 32'h0);
        chk({30'h0, rs}, {30'h0, uct_pkg::RESP_OKAY});
        acc(1'b1, 12'h010, 8'h5a);
        chk({30'h0, rs}, {30'h0, uct_pkg::RESP_SLVERR});
        for (int k = 0; k < 4; k++) begin
            acc(1'b1, CT, 8'h10 << k);
            acc(1'b0, CT, 8'h00);
            chk(rd_v, 32'h10 << k);
            @(posedge ref_clk) flg <= 4'h1 << k;
            wt(2);
            chk({31'h0, serial_irq}, 32'h1);
            @(posedge ref_clk) flg <= ~(4'h1 << k);
            wt(2);
            chk({31'h0, serial_irq}, 32'h0);
        end
        acc(1'b1, CT, 8'h0c);
        wt(1);
        chk({28'h0, tx_run, rx_run, tx_pin_oe, rx_pin_own}, 32'hf);
        acc(1'b1, CF, 8'h01);
        wt(1);
        chk({30'h0, loop_route, rx_pin_own}, 32'h2);
        acc(1'b1, CF, 8'h03);
        wt(1);
        chk({31'h0, tx_pin_oe}, 32'h0);
        acc(1'b1, CF, 8'h07);
        wt(1);
        chk({31'h0, tx_pin_oe}, 32'h1);
        acc(1'b1, CF, 8'h00);
        @(posedge ref_clk) busy_hold <= 1'b1;
        acc(1'b1, CT, 8'h04);
        acc(1'b1, CT, 8'h0c);
        wt(1);
        chk({31'h0, idle_req}, 32'h1);
        acc(1'b0, uct_pkg::OFF_STATUS, 8'h00);
        chk(rd_v, 32'h0000_070b);
        @(posedge ref_clk) busy_hold <= 1'b0;
        wt(3);
        chk(32'(idle_n), 32'h1);
        acc(1'b1, CT, 8'h00);
        wt(1);
        chk({31'h0, tx_pin_oe}, 32'h1);
        wt(12);
        chk({31'h0, tx_pin_oe}, 32'h0);
        acc(1'b1, CF, 8'h08);
        wt(1);
        chk({31'h0, long_break_sel}, 32'h1);
        acc(1'b1, CT, 8'h01);
        wt(30);
        acc(1'b1, CT, 8'h00);
        wt(40);
        chk({31'h0, break_req}, 32'h0);
        chk({31'h0, brk_n >= 3 && brk_n <= 5}, 32'h1);
        for (int m = 0; m < 2; m++) begin
            acc(1'b1, CF, m[0] ? 8'h10 : 8'h00);
            acc(1'b1, CT, 8'h02);
            wt(1);
            chk({31'h0, rx_standby}, 32'h1);
            hit(m == 0);
            chk({31'h0, rx_standby}, 32'h1);
            hit(m == 1);
            chk({31'h0, rx_standby}, 32'h0);
        end
        wrap_up();
    end
endmodule : tb_top
